// ==== pkg/ident_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface ident_if;
  logic [1:0]  addr;
  logic [15:0] wdata;
  logic        wr;
  logic        rd;
  logic [31:0] rdata;
  logic        power_stage_enable_input;
  logic        controller_enable_input;
  logic        class1_diagnostic;

  modport device (
    input  addr,
    input  wdata,
    input  wr,
    input  rd,
    input  power_stage_enable_input,
    input  controller_enable_input,
    output rdata,
    output class1_diagnostic
  );

  modport master (
    output addr,
    output wdata,
    output wr,
    output rd,
    output power_stage_enable_input,
    output controller_enable_input,
    input  rdata,
    input  class1_diagnostic
  );
endinterface
`default_nettype wire

// ==== pkg/ident_pkg.sv ====
package ident_pkg;
  // device side: index of each register reached through the link
  localparam int          CMD_W          = 16;
  localparam int          STAT_W         = 32;
  localparam int          HALF_W         = 16;
  localparam int          IDX_W          = 2;
  localparam logic [1:0]  IDX_CUR_CMD    = 2'h0;
  localparam logic [1:0]  IDX_ENC_CMD    = 2'h1;
  localparam logic [1:0]  IDX_STATUS     = 2'h2;
  // command word layout
  localparam int          CMD_SET_BIT    = 0;
  localparam int          CMD_BUSY_BIT   = 8;
  localparam int          CMD_OK_BIT     = 9;
  localparam int          CMD_ERR_BIT    = 10;
  localparam logic [15:0] CMD_RESET      = 16'h0000;
  // status word, per half (high half = encoder command)
  localparam int          ST_SUM_BIT     = 0;
  localparam int          ST_CTL_ON_BIT  = 1;
  localparam int          ST_PWR_OFF_BIT = 2;
  localparam logic [15:0] ST_RESET       = 16'h0000;
  localparam logic [15:0] CUR_FAIL_MASK  = 16'h0018;
  localparam logic [15:0] CUR_REPORT_MSK = 16'h8018;
  localparam logic [15:0] ENC_FAIL_MASK  = 16'h07f8;
  localparam logic [15:0] ENC_REPORT_MSK = 16'h07f8;
  // identified results
  localparam int          GAIN_W         = 32;
  localparam int          TC_W           = 32;
  localparam int          POLES_W        = 8;
  localparam int          OFFS_W         = 16;
  // controller side: plain register port
  localparam int          M_ADDR_W       = 3;
  localparam logic [2:0]  M_CTRL         = 3'h0;
  localparam logic [2:0]  M_CMD          = 3'h1;
  localparam logic [2:0]  M_STAT         = 3'h2;
  localparam logic [2:0]  M_IDENT        = 3'h3;
  localparam logic [2:0]  M_IRQ_STAT     = 3'h4;
  localparam logic [2:0]  M_IRQ_MASK     = 3'h5;
  localparam int          CTRL_PWR_BIT   = 0;
  localparam int          CTRL_CTL_BIT   = 1;
  localparam int          MCMD_CUR_BIT   = 0;
  localparam int          MCMD_ENC_BIT   = 1;
  localparam int          MST_BUSY_BIT   = 0;
  localparam int          MST_WHICH_BIT  = 1;
  localparam int          MST_OK_BIT     = 2;
  localparam int          MST_ERR_BIT    = 3;
  localparam int          MST_C1_BIT     = 4;
  localparam int          IRQ_W          = 5;
  localparam int          IRQ_CUR_OK     = 0;
  localparam int          IRQ_CUR_ERR    = 1;
  localparam int          IRQ_ENC_OK     = 2;
  localparam int          IRQ_ENC_ERR    = 3;
  localparam int          IRQ_REFUSED    = 4;
endpackage

// ==== rtl/ident_device.sv ====
// Added by the designer: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ident_device
  import ident_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_resetn,
  ident_if.device                  bus,
  input  wire logic                i_class1_fault,
  input  wire logic                i_engine_done,
  input  wire logic [HALF_W-1:0]   i_engine_errors,
  input  wire logic [GAIN_W-1:0]   i_cur_gain,
  input  wire logic [TC_W-1:0]     i_cur_time_const,
  input  wire logic [POLES_W-1:0]  i_pole_count,
  input  wire logic [OFFS_W-1:0]   i_enc_offset,
  input  wire logic                i_phase_seq,
  output logic                     o_engine_start,
  output logic                     o_engine_mode,
  output logic                     o_engine_abort,
  output logic                     o_busy,
  output logic [GAIN_W-1:0]        o_cur_gain,
  output logic [TC_W-1:0]          o_cur_time_const,
  output logic [POLES_W-1:0]       o_pole_count,
  output logic [OFFS_W-1:0]        o_enc_offset,
  output logic                     o_phase_seq
);

  typedef enum logic [1:0] {RUN_IDLE, RUN_CUR, RUN_ENC} run_t;

  run_t              state_reg;
  run_t              state_next;
  logic [1:0]        set_reg;
  logic [1:0]        ok_reg;
  logic [1:0]        err_reg;
  logic [HALF_W-1:0] half_reg [2];
  logic [HALF_W-1:0] half_next [2];
  logic [1:0]        set_next;
  logic [1:0]        ok_next;
  logic [1:0]        err_next;
  logic              class1_reg;
  logic [31:0]       rdata_reg;
  logic              start_reg;
  logic              mode_reg;
  logic              abort_reg;
  logic [1:0]        wr_cmd;
  logic [1:0]        start_cmd;
  logic [1:0]        clear_cmd;
  logic [1:0]        run_cmd;
  logic [1:0]        fail_cmd;
  logic [1:0]        done_cmd;
  logic [HALF_W-1:0] fail_mask [2];
  logic [HALF_W-1:0] report_mask [2];
  logic [HALF_W-1:0] pre_half;
  logic              pre_bad;
  logic              pwr_drop;
  logic              eng_idle;
  logic [CMD_W-1:0]  cmd_word [2];
  logic [31:0]       rdata_next;

  assign fail_mask[0]   = CUR_FAIL_MASK;
  assign fail_mask[1]   = ENC_FAIL_MASK;
  assign report_mask[0] = CUR_REPORT_MSK;
  assign report_mask[1] = ENC_REPORT_MSK;

  // start preconditions checked the moment the command is written
  assign pre_bad  = !bus.power_stage_enable_input || bus.controller_enable_input
                    || class1_reg;
  assign eng_idle = (state_reg == RUN_IDLE);
  assign pwr_drop = !eng_idle && !bus.power_stage_enable_input;

  always_comb
  begin
    pre_half                 = ST_RESET;
    pre_half[ST_SUM_BIT]     = pre_bad;
    pre_half[ST_CTL_ON_BIT]  = bus.controller_enable_input;
    pre_half[ST_PWR_OFF_BIT] = !bus.power_stage_enable_input;
  end

  genvar k;
  generate
    for (k = 0; k < 2; k++)
    begin : g_cmd
      logic [HALF_W-1:0] eng_bits;
      logic              eng_fail;

      assign wr_cmd[k]    = bus.wr && (bus.addr == (k == 0 ? IDX_CUR_CMD : IDX_ENC_CMD));
      // a start needs the set bit rising; a repeat write of one is ignored
      assign start_cmd[k] = wr_cmd[k] && bus.wdata[CMD_SET_BIT] && !set_reg[k] && eng_idle;
      assign clear_cmd[k] = wr_cmd[k] && !bus.wdata[CMD_SET_BIT];
      assign run_cmd[k]   = (k == 0) ? (state_reg == RUN_CUR) : (state_reg == RUN_ENC);
      assign eng_bits     = i_engine_errors & report_mask[k];
      assign eng_fail     = |(i_engine_errors & fail_mask[k]);

      // power loss outranks a finish seen in the same cycle
      assign fail_cmd[k]  = (start_cmd[k] && pre_bad)
                            || (run_cmd[k] && !clear_cmd[k] && pwr_drop)
                            || (run_cmd[k] && !clear_cmd[k] && i_engine_done && eng_fail);
      assign done_cmd[k]  = run_cmd[k] && !clear_cmd[k] && !pwr_drop
                            && i_engine_done && !eng_fail;

      always_comb
      begin
        half_next[k] = half_reg[k];
        if (start_cmd[k])
          half_next[k] = pre_bad ? pre_half : ST_RESET;
        else if (run_cmd[k] && !clear_cmd[k] && pwr_drop)
        begin
          half_next[k][ST_PWR_OFF_BIT] = 1'b1;
          half_next[k][ST_SUM_BIT]     = 1'b1;
        end
        else if (run_cmd[k] && !clear_cmd[k] && i_engine_done)
        begin
          half_next[k]             = half_reg[k] | eng_bits;
          half_next[k][ST_SUM_BIT] = eng_fail;
        end
      end

      assign set_next[k] = start_cmd[k] ? 1'b1 : (clear_cmd[k] ? 1'b0 : set_reg[k]);
      assign ok_next[k]  = clear_cmd[k] ? 1'b0 : (ok_reg[k] | done_cmd[k]);
      assign err_next[k] = clear_cmd[k] ? 1'b0 : (err_reg[k] | fail_cmd[k]);

      always_comb
      begin
        cmd_word[k]               = CMD_RESET;
        cmd_word[k][CMD_SET_BIT]  = set_reg[k];
        cmd_word[k][CMD_BUSY_BIT] = run_cmd[k];
        cmd_word[k][CMD_OK_BIT]   = ok_reg[k];
        cmd_word[k][CMD_ERR_BIT]  = err_reg[k];
      end

      always_ff @(posedge i_clk or negedge i_resetn)
      begin
        if (!i_resetn)
        begin
          half_reg[k] <= ST_RESET;
          set_reg[k]  <= 1'b0;
          ok_reg[k]   <= 1'b0;
          err_reg[k]  <= 1'b0;
        end
        else
        begin
          half_reg[k] <= half_next[k];
          set_reg[k]  <= set_next[k];
          ok_reg[k]   <= ok_next[k];
          err_reg[k]  <= err_next[k];
        end
      end
    end
  endgenerate

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      RUN_IDLE:
      begin
        if (start_cmd[0] && !pre_bad)
          state_next = RUN_CUR;
        else if (start_cmd[1] && !pre_bad)
          state_next = RUN_ENC;
      end
      RUN_CUR:
      begin
        if (clear_cmd[0] || fail_cmd[0] || done_cmd[0])
          state_next = RUN_IDLE;
      end
      RUN_ENC:
      begin
        if (clear_cmd[1] || fail_cmd[1] || done_cmd[1])
          state_next = RUN_IDLE;
      end
      default:
        state_next = RUN_IDLE;
    endcase
  end

  // status word answers at any time, also mid-run
  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (bus.rd && bus.addr == IDX_CUR_CMD)
      rdata_next = {16'h0000, cmd_word[0]};
    else if (bus.rd && bus.addr == IDX_ENC_CMD)
      rdata_next = {16'h0000, cmd_word[1]};
    else if (bus.rd && bus.addr == IDX_STATUS)
      rdata_next = {half_reg[1], half_reg[0]};
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg  <= RUN_IDLE;
      class1_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      start_reg  <= 1'b0;
      mode_reg   <= 1'b0;
      abort_reg  <= 1'b0;
    end
    else
    begin
      state_reg  <= state_next;
      class1_reg <= i_class1_fault;
      rdata_reg  <= rdata_next;
      start_reg  <= (start_cmd[0] || start_cmd[1]) && !pre_bad;
      if (start_cmd[1])
        mode_reg <= 1'b1;
      else if (start_cmd[0])
        mode_reg <= 1'b0;
      abort_reg  <= (run_cmd[0] && (clear_cmd[0] || pwr_drop))
                    || (run_cmd[1] && (clear_cmd[1] || pwr_drop));
    end
  end

  // results only replace the stored set on a clean finish
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_cur_gain       <= '0;
      o_cur_time_const <= '0;
      o_pole_count     <= '0;
      o_enc_offset     <= '0;
      o_phase_seq      <= 1'b0;
    end
    else
    begin
      if (done_cmd[0])
      begin
        o_cur_gain       <= i_cur_gain;
        o_cur_time_const <= i_cur_time_const;
      end
      if (done_cmd[1])
      begin
        o_pole_count <= i_pole_count;
        o_enc_offset <= i_enc_offset;
        o_phase_seq  <= i_phase_seq;
      end
    end
  end

  assign bus.rdata             = rdata_reg;
  assign bus.class1_diagnostic = class1_reg;
  assign o_engine_start        = start_reg;
  assign o_engine_mode         = mode_reg;
  assign o_engine_abort        = abort_reg;
  assign o_busy                = !eng_idle;

endmodule
`default_nettype wire

// ==== rtl/ident_master.sv ====
`timescale 1ns/10ps
`default_nettype none
module ident_master
  import ident_pkg::*;
(
  input  wire logic                i_clk,
  input  wire logic                i_resetn,
  input  wire logic [M_ADDR_W-1:0] i_addr,
  input  wire logic [31:0]         i_wdata,
  input  wire logic                i_wr,
  input  wire logic                i_rd,
  output logic [31:0]              o_rdata,
  output logic                     o_irq,
  ident_if.master                  bus
);

  typedef enum logic [2:0] {M_IDLE, M_POLL, M_GAP1, M_GET_CMD, M_GAP2, M_GET_ST, M_CLEAN} mst_t;

  mst_t             state_reg;
  logic             pwr_reg;
  logic             ctl_reg;
  logic             which_reg;
  logic             ok_reg;
  logic             err_reg;
  logic [CMD_W-1:0] cmdw_reg;
  logic [31:0]      ident_reg;
  logic [IRQ_W-1:0] irq_stat_reg;
  logic [IRQ_W-1:0] irq_mask_reg;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_stat_next;
  logic [31:0]      rdata_reg;
  logic             irq_reg;
  logic [1:0]       addr_reg;
  logic [15:0]      wdata_reg;
  logic             wr_reg;
  logic             rd_reg;
  logic             idle;
  logic             req;
  logic             req_enc;
  logic             may_start;
  logic             start;
  logic             finished;
  logic             fin_err;
  logic [1:0]       cmd_idx;
  logic [31:0]      rdata_next;

  assign idle      = (state_reg == M_IDLE);
  assign req       = i_wr && i_addr == M_CMD && (i_wdata[MCMD_CUR_BIT] || i_wdata[MCMD_ENC_BIT]);
  assign req_enc   = !i_wdata[MCMD_CUR_BIT];
  // refuse unless idle, enabled, controller off and no class-1 diagnostic
  assign may_start = idle && pwr_reg && !ctl_reg && !bus.class1_diagnostic;
  assign start     = req && may_start;
  assign cmd_idx   = which_reg ? IDX_ENC_CMD : IDX_CUR_CMD;
  assign finished  = cmdw_reg[CMD_OK_BIT] || cmdw_reg[CMD_ERR_BIT];
  assign fin_err   = cmdw_reg[CMD_ERR_BIT];

  always_comb
  begin
    irq_set                = '0;
    irq_set[IRQ_REFUSED]   = req && !may_start;
    if (state_reg == M_GET_ST && finished)
    begin
      irq_set[IRQ_CUR_OK]  = !which_reg && !fin_err;
      irq_set[IRQ_CUR_ERR] = !which_reg && fin_err;
      irq_set[IRQ_ENC_OK]  = which_reg && !fin_err;
      irq_set[IRQ_ENC_ERR] = which_reg && fin_err;
    end
  end

  // a new event wins over a clear in the same cycle
  assign irq_stat_next = (irq_stat_reg & ~((i_wr && i_addr == M_IRQ_STAT) ? i_wdata[IRQ_W-1:0] : '0))
                         | irq_set;

  always_comb
  begin
    rdata_next = 32'h0000_0000;
    if (i_rd && i_addr == M_CTRL)
      rdata_next = {30'h0, ctl_reg, pwr_reg};
    else if (i_rd && i_addr == M_STAT)
      rdata_next = {27'h0, bus.class1_diagnostic, err_reg, ok_reg, which_reg, !idle};
    else if (i_rd && i_addr == M_IDENT)
      rdata_next = ident_reg;
    else if (i_rd && i_addr == M_IRQ_STAT)
      rdata_next = {27'h0, irq_stat_reg};
    else if (i_rd && i_addr == M_IRQ_MASK)
      rdata_next = {27'h0, irq_mask_reg};
  end

  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      pwr_reg      <= 1'b0;
      ctl_reg      <= 1'b0;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      rdata_reg    <= 32'h0000_0000;
      irq_reg      <= 1'b0;
    end
    else
    begin
      // enables frozen while a command runs
      if (i_wr && i_addr == M_CTRL && idle)
      begin
        pwr_reg <= i_wdata[CTRL_PWR_BIT];
        ctl_reg <= i_wdata[CTRL_CTL_BIT];
      end
      if (i_wr && i_addr == M_IRQ_MASK)
        irq_mask_reg <= i_wdata[IRQ_W-1:0];
      irq_stat_reg <= irq_stat_next;
      rdata_reg    <= rdata_next;
      irq_reg      <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // read data arrive one cycle after the read strobe leaves this block
  always_ff @(posedge i_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      state_reg <= M_IDLE;
      which_reg <= 1'b0;
      ok_reg    <= 1'b0;
      err_reg   <= 1'b0;
      cmdw_reg  <= CMD_RESET;
      ident_reg <= 32'h0000_0000;
      addr_reg  <= IDX_CUR_CMD;
      wdata_reg <= CMD_RESET;
      wr_reg    <= 1'b0;
      rd_reg    <= 1'b0;
    end
    else
    begin
      wr_reg <= 1'b0;
      rd_reg <= 1'b0;
      case (state_reg)
        M_IDLE:
        begin
          if (start)
          begin
            which_reg              <= req_enc;
            ok_reg                 <= 1'b0;
            err_reg                <= 1'b0;
            cmdw_reg               <= CMD_RESET;
            addr_reg               <= req_enc ? IDX_ENC_CMD : IDX_CUR_CMD;
            wdata_reg              <= CMD_RESET;
            wdata_reg[CMD_SET_BIT] <= 1'b1;
            wr_reg                 <= 1'b1;
            state_reg              <= M_POLL;
          end
        end
        M_POLL, M_GET_ST:
        begin
          if (state_reg == M_GET_ST)
            ident_reg <= bus.rdata;
          addr_reg  <= cmd_idx;
          if (state_reg == M_GET_ST && finished)
          begin
            ok_reg    <= !fin_err;
            err_reg   <= fin_err;
            wdata_reg <= CMD_RESET;
            wr_reg    <= 1'b1;
            state_reg <= M_CLEAN;
          end
          else
          begin
            rd_reg    <= 1'b1;
            state_reg <= M_GAP1;
          end
        end
        M_GAP1:
          state_reg <= M_GET_CMD;
        M_GET_CMD:
        begin
          cmdw_reg  <= bus.rdata[CMD_W-1:0];
          addr_reg  <= IDX_STATUS;
          rd_reg    <= 1'b1;
          state_reg <= M_GAP2;
        end
        M_GAP2:
          state_reg <= M_GET_ST;
        default:
          state_reg <= M_IDLE;
      endcase
    end
  end

  assign bus.addr                     = addr_reg;
  assign bus.wdata                    = wdata_reg;
  assign bus.wr                       = wr_reg;
  assign bus.rd                       = rd_reg;
  assign bus.power_stage_enable_input = pwr_reg;
  assign bus.controller_enable_input  = ctl_reg;
  assign o_rdata                      = rdata_reg;
  assign o_irq                        = irq_reg;

endmodule
`default_nettype wire

// ==== sim/ident_link_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module ident_link_sva
  import ident_pkg::*;
(
  input wire logic        i_clk,
  input wire logic        i_resetn,
  input wire logic [1:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  input wire logic        power_stage_enable_input,
  input wire logic        controller_enable_input,
  input wire logic        class1_diagnostic
);
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_resetn);

  wire cmd_idx  = (addr == IDX_CUR_CMD) || (addr == IDX_ENC_CMD);
  wire start_wr = wr && cmd_idx && wdata[CMD_SET_BIT];
  wire cmd_rd   = rd && cmd_idx;
  wire stat_rd  = rd && (addr == IDX_STATUS);
  wire cur_rd   = rd && (addr == IDX_CUR_CMD);
  wire done_seen = rdata[CMD_OK_BIT] || rdata[CMD_ERR_BIT];

  AST_NO_WR_RD: assert property (!(wr && rd))
    else $error("read and write strobes high together");
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == '0)
    else $error("read data not zero outside the answer cycle");
  AST_START_POWERED: assert property (start_wr |-> power_stage_enable_input && !controller_enable_input)
    else $error("command started without power stage or with controller on");
  AST_START_NO_FAULT: assert property (start_wr |-> !$past(class1_diagnostic))
    else $error("command started with a class-1 fault pending");
  AST_BUSY_ECHO: assert property (cmd_rd ##1 rdata[CMD_BUSY_BIT] |-> rdata[CMD_SET_BIT])
    else $error("busy command word without start echo");
  AST_OK_ERR_EXCL: assert property (cmd_rd |=> !(rdata[CMD_OK_BIT] && rdata[CMD_ERR_BIT]))
    else $error("command word shows ok and error together");
  AST_DONE_NOT_BUSY: assert property (cmd_rd |=> !(rdata[CMD_BUSY_BIT] && done_seen))
    else $error("command word busy and finished together");
  AST_SUM_LO: assert property (stat_rd ##1 (rdata[4:1] != 4'h0) |-> rdata[ST_SUM_BIT])
    else $error("tuning error without summary bit");
  AST_SUM_HI: assert property (stat_rd ##1 (rdata[26:17] != 10'h000) |-> rdata[HALF_W+ST_SUM_BIT])
    else $error("encoder error without summary bit");
  AST_CLEAR_AFTER_END: assert property (cur_rd ##1 done_seen |-> ##[1:4] (wr && addr == IDX_CUR_CMD && !wdata[0]))
    else $error("finished command not cleared by the master");

  cover property (start_wr && addr == IDX_CUR_CMD);
  cover property (start_wr && addr == IDX_ENC_CMD);
  cover property (cmd_rd ##1 rdata[CMD_ERR_BIT]);
endmodule
`default_nettype wire

// ==== sim/motor_ident_command_sequencer_tb.sv ====
`timescale 1ns/10ps
`default_nettype none
module motor_ident_command_sequencer_tb
  import ident_pkg::*;
;
  logic        i_clk, i_resetn, i_wr, i_rd, o_irq, fault, done, ph_in, start, mode, abort, busy, ph_out, eph;
  logic [2:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, gain_in, tc_in, gain_out, tc_out, eg, et, d, es;
  logic [15:0] errs, offs_in, offs_out, eo;
  logic [7:0]  poles_in, poles_out, ep;
  int          fail_count, compares, starts;

  ident_if i_ident_if();
  ident_master i_ident_master(.i_clk(i_clk), .i_resetn(i_resetn), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq), .bus(i_ident_if));
  ident_device i_ident_device(.i_clk(i_clk), .i_resetn(i_resetn), .bus(i_ident_if), .i_class1_fault(fault),
    .i_engine_done(done), .i_engine_errors(errs), .i_cur_gain(gain_in), .i_cur_time_const(tc_in),
    .i_pole_count(poles_in), .i_enc_offset(offs_in), .i_phase_seq(ph_in), .o_engine_start(start),
    .o_engine_mode(mode), .o_engine_abort(abort), .o_busy(busy), .o_cur_gain(gain_out),
    .o_cur_time_const(tc_out), .o_pole_count(poles_out), .o_enc_offset(offs_out), .o_phase_seq(ph_out));
  ident_link_sva i_ident_link_sva(.i_clk(i_clk), .i_resetn(i_resetn), .addr(i_ident_if.addr),
    .wdata(i_ident_if.wdata), .wr(i_ident_if.wr), .rd(i_ident_if.rd), .rdata(i_ident_if.rdata),
    .power_stage_enable_input(i_ident_if.power_stage_enable_input),
    .controller_enable_input(i_ident_if.controller_enable_input),
    .class1_diagnostic(i_ident_if.class1_diagnostic));

  initial
  begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  // sampled on the falling edge, clear of the launching edge
  always @(negedge i_clk)
    if (start === 1'b1)
      starts++;

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task sw_wr(input logic [2:0] a, input logic [31:0] v);
    @(posedge i_clk);
    i_addr  <= a;
    i_wdata <= v;
    i_wr    <= 1'b1;
    @(posedge i_clk);
    i_wr    <= 1'b0;
  endtask

  task sw_rd(input logic [2:0] a, output logic [31:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_rd   <= 1'b1;
    @(posedge i_clk);
    i_rd   <= 1'b0;
    @(negedge i_clk);
    v = o_rdata;
  endtask

  // bounded poll: a lost event ends as a mismatch, not a hang
  task wait_irq(input int b);
    for (int n = 0; n < 40; n++)
    begin
      sw_rd(M_IRQ_STAT, d);
      if (d[b] === 1'b1)
        break;
    end
    chk(d[b], 1'b1);
  endtask

  task clear_irq(input int b);
    sw_wr(M_IRQ_STAT, 32'h1 << b);
    sw_rd(M_IRQ_STAT, d);
    chk(d[b], 1'b0);
    chk(o_irq, 1'b0);
  endtask

  task refuse(input logic [31:0] cmd, input logic irq_exp);
    int s0;
    s0 = starts;
    sw_wr(M_CMD, cmd);
    wait_irq(IRQ_REFUSED);
    chk(starts, s0);
    chk(o_irq, irq_exp);
    clear_irq(IRQ_REFUSED);
  endtask

  task run_cmd(input logic [31:0] cmd, input logic [15:0] e, input logic [31:0] v);
    int n, s0, b;
    logic enc, ok;
    enc = (cmd == 32'h2);
    ok = ((e & (enc ? ENC_FAIL_MASK : CUR_FAIL_MASK)) == 16'h0000);
    b = enc ? (ok ? IRQ_ENC_OK : IRQ_ENC_ERR) : (ok ? IRQ_CUR_OK : IRQ_CUR_ERR);
    s0 = starts;
    sw_wr(M_CMD, cmd);
    n = 0;
    while (starts == s0 && n < 20)
    begin
      @(negedge i_clk);
      n++;
    end
    chk(starts, s0 + 1);
    chk(busy, 1'b1);
    chk(mode, enc);
    sw_rd(M_STAT, d);
    chk(d[MST_BUSY_BIT], 1'b1);
    // enables must stay frozen while the command runs
    sw_wr(M_CTRL, 32'h2);
    sw_rd(M_CTRL, d);
    chk(d, 32'h1);
    if (enc)
      es[31:16] = 16'h0000;
    else
      es[15:0] = 16'h0000;
    sw_rd(M_IDENT, d);
    chk(d, es);
    @(posedge i_clk);
    {gain_in, tc_in, poles_in, offs_in, ph_in} <= {v, ~v, v[7:0], v[15:0], v[0]};
    errs <= e;
    done <= 1'b1;
    @(posedge i_clk);
    done <= 1'b0;
    wait_irq(b);
    sw_rd(M_STAT, d);
    chk(d[MST_OK_BIT], ok);
    chk(d[MST_ERR_BIT], !ok);
    chk(d[MST_WHICH_BIT], enc);
    chk(o_irq, 1'b1);
    clear_irq(b);
    if (enc)
      es[31:16] = (e & ENC_REPORT_MSK) | {15'h0, !ok};
    else
      es[15:0] = (e & CUR_REPORT_MSK) | {15'h0, !ok};
    sw_rd(M_IDENT, d);
    chk(d, es);
    if (ok && !enc)
      {eg, et} = {v, ~v};
    if (ok && enc)
      {ep, eo, eph} = {v[7:0], v[15:0], v[0]};
    chk(busy, 1'b0);
    chk(gain_out, eg);
    chk(tc_out, et);
    chk(poles_out, ep);
    chk(offs_out, eo);
    chk(ph_out, eph);
    $display("test run cmd=%h errs=%h done", cmd, e);
  endtask

  task report_and_stop;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    // whole sequence is well under 5000 cycles
    #(100 * 30000);
    fail_count++;
    report_and_stop;
  end

  initial
  begin
    {i_resetn, i_wr, i_rd, fault, done, ph_in, i_addr, i_wdata, gain_in, tc_in, errs, offs_in, poles_in} = '0;
    {eg, et, es, eo, ep, eph, fail_count, compares, starts} = '0;
    repeat (5) @(posedge i_clk);
    i_resetn <= 1'b1;
    sw_rd(M_STAT, d);
    chk(d, 32'h0);
    sw_rd(M_IRQ_STAT, d);
    chk(d, 32'h0);
    sw_rd(3'h7, d);
    chk(d, 32'h0);
    chk(o_irq, 1'b0);
    chk(gain_out, 32'h0);
    $display("test reset done");
    refuse(32'h1, 1'b0);
    sw_wr(M_IRQ_MASK, 32'h1f);
    sw_rd(M_IRQ_MASK, d);
    chk(d, 32'h1f);
    sw_wr(M_CTRL, 32'h3);
    refuse(32'h2, 1'b1);
    sw_wr(M_CTRL, 32'h1);
    @(posedge i_clk);
    fault <= 1'b1;
    repeat (3) @(posedge i_clk);
    sw_rd(M_STAT, d);
    chk(d[MST_C1_BIT], 1'b1);
    refuse(32'h1, 1'b1);
    @(posedge i_clk);
    fault <= 1'b0;
    repeat (3) @(posedge i_clk);
    $display("test refusals done");
    run_cmd(32'h1, 16'h8000, 32'h1234_5678);
    run_cmd(32'h1, 16'h0008, 32'h5555_aaaa);
    run_cmd(32'h2, 16'h0000, 32'h0000_4321);
    run_cmd(32'h2, 16'h0100, 32'h9999_8888);
    run_cmd(32'h3, 16'h0010, 32'h7777_6666);
    report_and_stop;
  end
endmodule
`default_nettype wire
